// ---- panel_regs_params.svh ----
// constants for the panel clock, window and power register bank
`ifndef PANEL_REGS_PARAMS_SVH
`define PANEL_REGS_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_FB_DIV 8'hC8
`define IDX_REF_DIV 8'hC9
`define IDX_MUX_DIV 8'hCA
`define IDX_PHASE_A 8'hCB
`define IDX_PHASE_B 8'hCC
`define IDX_AA_CTRL 8'hCD
`define IDX_HSTART_LO 8'hD8
`define IDX_HSTART_HI 8'hD9
`define IDX_VSTART_LO 8'hDA
`define IDX_VSTART_HI 8'hDB
`define IDX_HSIZE_LO 8'hDC
`define IDX_HSIZE_HI 8'hDD
`define IDX_VSIZE_LO 8'hDE
`define IDX_VSIZE_HI 8'hDF
`define IDX_POWER 8'hE0

// reset values
`define RST_FB_DIV 8'h15
`define RST_REF_DIV 8'h02
`define RST_MUX_DIV 8'h01
`define RST_PHASE_A 8'h00
`define RST_PHASE_B 8'h00
`define RST_AA_CTRL 8'h00
`define RST_WIN_ZERO 8'h00
`define RST_HSIZE_LO 8'hE0
`define RST_HSIZE_HI 8'h01
`define RST_VSIZE_LO 8'hEA
`define RST_POWER 8'h9C

// bus geometry
`define ADDR_W 12
`define NUM_REGS 15
`define SLOT_W 4
`define IDX_LSB 2
`define IDX_MSB 9

// power register bits
`define PWR_PADS_N 7
`define PWR_LINEMEM 6
`define PWR_COMB_N 4
`define PWR_OE_C_N 3
`define PWR_OE_B_N 2
`define PWR_OE_A_N 1
`define PWR_DC_N 0

// field positions inside their registers
`define FB_DIV_MSB 6
`define REF_DIV_MSB 4
`define SRC_MSB 7
`define SRC_LSB 6
`define PLL_PD_BIT 5
`define DOUBLE_DIV_BIT 4
`define EXDIV_MSB 3
`define EXDIV_LSB 2
`define POST_DIV_MSB 1
`define PHASE_MSB 7
`define PHASE_LSB 4
`define AUX_DIV_MSB 3
`define AA_EN_BIT 0
`define HI_NIB_MSB 3

// extra-division codes at or above this are unused
`define EXDIV_LIMIT 2'h2

`endif

// ---- panel_regs_pkg.sv ----
// types shared by the panel clock, window and power register bank
package panel_regs_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    SRC_PLL = 2'b00,
    SRC_REF = 2'b01,
    SRC_HIGH = 2'b10,
    SRC_HIGH_ALT = 2'b11
  } clk_src_e;
endpackage : panel_regs_pkg

// ---- panel_clock_window_power_regs.sv ----
// APB register bank for display PLL, window and power controls
`timescale 1ns/1ps
`include "panel_regs_params.svh"

module panel_clock_window_power_regs (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // context from neighbouring logic
  input wire logic serial_rgb_en,
  input wire logic pll_clk,
  input wire logic ref_clk,
  // display pll
  output logic [6:0] pll_fb_div,
  output logic [4:0] pll_ref_div,
  output logic [1:0] clk_src_select,
  output logic display_pll_powerdown,
  output logic pll_output_double_div,
  output logic [1:0] pll_extra_div,
  output logic [1:0] pll_post_div,
  output logic pix_clk,
  // timing clock phase
  output logic [3:0] phase_clk_a,
  output logic [3:0] phase_clk_c,
  output logic [3:0] phase_aux_div,
  // main window
  output logic subpixel_aa_en,
  output logic [11:0] main_win_h_start,
  output logic [11:0] main_win_v_start,
  output logic [11:0] main_win_h_size,
  output logic [11:0] main_win_v_size,
  // power
  output logic pad_powerdown_n,
  output logic other_pads_en,
  output logic decoder_linemem_pd,
  output logic comb_decoder_pd_n,
  output logic timing_clk_a_oe,
  output logic timing_clk_b_oe,
  output logic timing_clk_c_oe,
  output logic dc_iface_pd_n
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic hit;
  logic [3:0] slot;
  logic setup_ph;
  logic wr_take;

  assign idx = paddr[`IDX_MSB:`IDX_LSB];
  assign setup_ph = psel && !penable;

  always_comb
  begin
    hit = 1'b1;
    slot = 4'h0;
    case (idx)
      `IDX_FB_DIV: slot = 4'h0;
      `IDX_REF_DIV: slot = 4'h1;
      `IDX_MUX_DIV: slot = 4'h2;
      `IDX_PHASE_A: slot = 4'h3;
      `IDX_PHASE_B: slot = 4'h4;
      `IDX_AA_CTRL: slot = 4'h5;
      `IDX_HSTART_LO: slot = 4'h6;
      `IDX_HSTART_HI: slot = 4'h7;
      `IDX_VSTART_LO: slot = 4'h8;
      `IDX_VSTART_HI: slot = 4'h9;
      `IDX_HSIZE_LO: slot = 4'hA;
      `IDX_HSIZE_HI: slot = 4'hB;
      `IDX_VSIZE_LO: slot = 4'hC;
      `IDX_VSIZE_HI: slot = 4'hD;
      `IDX_POWER: slot = 4'hE;
      default: hit = 1'b0;
    endcase
    // misaligned or out-of-range addresses are refused
    if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0)
    begin
      hit = 1'b0;
    end
  end

  // zero wait states: data is staged during setup, so pready can stay high
  assign pready = 1'b1;
  assign wr_take = psel && penable && pwrite && hit;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  panel_regs_pkg::byte_t regs_q [`NUM_REGS];
  panel_regs_pkg::byte_t regs_d [`NUM_REGS];

  function automatic panel_regs_pkg::byte_t reset_val(input int unsigned s);
    panel_regs_pkg::byte_t v;
    case (s)
      0: v = `RST_FB_DIV;
      1: v = `RST_REF_DIV;
      2: v = `RST_MUX_DIV;
      3: v = `RST_PHASE_A;
      4: v = `RST_PHASE_B;
      5: v = `RST_AA_CTRL;
      10: v = `RST_HSIZE_LO;
      11: v = `RST_HSIZE_HI;
      12: v = `RST_VSIZE_LO;
      14: v = `RST_POWER;
      default: v = `RST_WIN_ZERO;
    endcase
    return v;
  endfunction : reset_val

  // whole byte stored, spare bits included, and used at once except the extra division, registered one cycle later
  always_comb
  begin
    for (int i = 0; i < `NUM_REGS; i++)
    begin
      regs_d[i] = regs_q[i];
    end
    if (wr_take)
    begin
      regs_d[slot] = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `NUM_REGS; i++)
      begin
        regs_q[i] <= reset_val(i);
      end
    end
    else
    begin
      for (int i = 0; i < `NUM_REGS; i++)
      begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pslverr_q;
  logic pslverr_d;

  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ph)
    begin
      pslverr_d = !hit;
      prdata_d = 32'h0000_0000;
      if (hit && !pwrite)
      begin
        prdata_d = {24'h00_0000, regs_q[slot]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // extra division gating
  // ----------------------------------------------------------------
  // unused codes or a parallel panel fall back to no extra division,
  // so a stray write cannot feed the pll an illegal ratio
  logic [1:0] exdiv_q;
  logic [1:0] exdiv_d;

  always_comb
  begin
    exdiv_d = 2'h0;
    if (serial_rgb_en && regs_q[2][`EXDIV_MSB:`EXDIV_LSB] < `EXDIV_LIMIT)
    begin
      exdiv_d = regs_q[2][`EXDIV_MSB:`EXDIV_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exdiv_q <= 2'h0;
    end
    else
    begin
      exdiv_q <= exdiv_d;
    end
  end

  // ----------------------------------------------------------------
  // field outputs
  // ----------------------------------------------------------------
  assign pll_fb_div = regs_q[0][`FB_DIV_MSB:0];
  assign pll_ref_div = regs_q[1][`REF_DIV_MSB:0];
  assign clk_src_select = regs_q[2][`SRC_MSB:`SRC_LSB];
  assign display_pll_powerdown = regs_q[2][`PLL_PD_BIT];
  assign pll_output_double_div = regs_q[2][`DOUBLE_DIV_BIT];
  assign pll_extra_div = exdiv_q;
  assign pll_post_div = regs_q[2][`POST_DIV_MSB:0];
  assign phase_clk_a = regs_q[3][`PHASE_MSB:`PHASE_LSB];
  assign phase_aux_div = regs_q[3][`AUX_DIV_MSB:0];
  assign phase_clk_c = regs_q[4][`PHASE_MSB:`PHASE_LSB];
  assign subpixel_aa_en = regs_q[5][`AA_EN_BIT];
  // no shadowing: a half-written value is visible between the two writes
  assign main_win_h_start = {regs_q[7][`HI_NIB_MSB:0], regs_q[6]};
  assign main_win_v_start = {regs_q[9][`HI_NIB_MSB:0], regs_q[8]};
  assign main_win_h_size = {regs_q[11][`HI_NIB_MSB:0], regs_q[10]};
  assign main_win_v_size = {regs_q[13][`HI_NIB_MSB:0], regs_q[12]};

  // clock source mux; glitches on switching are the user's concern
  always_comb
  begin
    case (panel_regs_pkg::clk_src_e'(regs_q[2][`SRC_MSB:`SRC_LSB]))
      panel_regs_pkg::SRC_PLL: pix_clk = pll_clk;
      panel_regs_pkg::SRC_REF: pix_clk = ref_clk;
      default: pix_clk = 1'b1;
    endcase
  end

  assign pad_powerdown_n = regs_q[14][`PWR_PADS_N];
  assign other_pads_en = regs_q[14][`PWR_PADS_N];
  assign decoder_linemem_pd = regs_q[14][`PWR_LINEMEM];
  assign comb_decoder_pd_n = regs_q[14][`PWR_COMB_N];
  // clocks A and B keep their pads through a pad power-down
  assign timing_clk_a_oe = !regs_q[14][`PWR_OE_A_N];
  assign timing_clk_b_oe = !regs_q[14][`PWR_OE_B_N];
  assign timing_clk_c_oe = !regs_q[14][`PWR_OE_C_N] && regs_q[14][`PWR_PADS_N];
  assign dc_iface_pd_n = regs_q[14][`PWR_DC_N];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic wr_at_fb;
  logic wr_at_ref;
  logic wr_at_mux;
  logic wr_at_hhi;
  logic wr_at_vslo;
  logic wr_at_pha;
  logic wr_at_phc;
  logic wr_at_aa;
  logic wr_at_vstlo;
  logic wr_at_hzhi;
  logic wr_at_pwr;

  assign wr_at_fb = wr_take && idx == `IDX_FB_DIV;
  assign wr_at_ref = wr_take && idx == `IDX_REF_DIV;
  assign wr_at_mux = wr_take && idx == `IDX_MUX_DIV;
  assign wr_at_hhi = wr_take && idx == `IDX_HSTART_HI;
  assign wr_at_vslo = wr_take && idx == `IDX_VSIZE_LO;
  assign wr_at_pha = wr_take && idx == `IDX_PHASE_A;
  assign wr_at_phc = wr_take && idx == `IDX_PHASE_B;
  assign wr_at_aa = wr_take && idx == `IDX_AA_CTRL;
  assign wr_at_vstlo = wr_take && idx == `IDX_VSTART_LO;
  assign wr_at_hzhi = wr_take && idx == `IDX_HSIZE_HI;
  assign wr_at_pwr = wr_take && idx == `IDX_POWER;

  fb_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_fb |=> pll_fb_div == $past(pwdata[6:0]))
    else $error("feedback divider did not take write");

  ref_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_ref |=> pll_ref_div == $past(pwdata[4:0]))
    else $error("reference divider did not take write");

  src_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_src_select[1] |-> pix_clk)
    else $error("pixel clock not held high");

  src_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    clk_src_select == 2'h1 |-> pix_clk == ref_clk)
    else $error("bypass does not pass reference clock");

  exdiv_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !serial_rgb_en || regs_q[2][`EXDIV_MSB] |=> pll_extra_div == 2'h0)
    else $error("extra division used while not allowed");

  exdiv_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    serial_rgb_en && !regs_q[2][`EXDIV_MSB]
      |=> pll_extra_div == $past(regs_q[2][`EXDIV_MSB:`EXDIV_LSB]))
    else $error("extra division not passed");

  post_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_mux |=> pll_post_div == $past(pwdata[1:0]) && clk_src_select == $past(pwdata[7:6]))
    else $error("mux register did not take write");

  hstart_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_hhi |=> main_win_h_start[11:8] == $past(pwdata[3:0])
      && $stable(main_win_h_start[7:0]))
    else $error("horizontal start high nibble wrong");

  vsize_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_vslo |=> main_win_v_size[7:0] == $past(pwdata[7:0]))
    else $error("vertical size low byte wrong");

  pad_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pad_powerdown_n |-> !other_pads_en && !timing_clk_c_oe)
    else $error("pads active during pad power-down");

  oe_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    timing_clk_a_oe == !regs_q[14][`PWR_OE_A_N]
      && timing_clk_b_oe == !regs_q[14][`PWR_OE_B_N])
    else $error("timing clock enables mismatch");

  read_back_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit && idx == `IDX_FB_DIV
      |=> prdata[7:0] == $past(regs_q[0]) && !pslverr)
    else $error("readback of feedback register wrong");

  unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup_ph && !hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  // a refused write must leave the feedback divider, anti-alias enable and vertical size untouched
  unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !hit
      |=> $stable(pll_fb_div) && $stable(subpixel_aa_en) && $stable(main_win_v_size))
    else $error("refused write changed a register");

  phase_a_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_pha |=> phase_clk_a == $past(pwdata[`PHASE_MSB:`PHASE_LSB])
      && phase_aux_div == $past(pwdata[`AUX_DIV_MSB:0]))
    else $error("first phase register did not take write");

  phase_c_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_phc |=> phase_clk_c == $past(pwdata[`PHASE_MSB:`PHASE_LSB]))
    else $error("second phase register did not take write");

  aa_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_aa |=> subpixel_aa_en == $past(pwdata[`AA_EN_BIT]))
    else $error("anti-alias enable did not take write");

  vstart_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_vstlo |=> main_win_v_start[7:0] == $past(pwdata[7:0])
      && $stable(main_win_v_start[11:8]))
    else $error("vertical start low byte wrong");

  hsize_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_hzhi |=> main_win_h_size[11:8] == $past(pwdata[`HI_NIB_MSB:0])
      && $stable(main_win_h_size[7:0]))
    else $error("horizontal size high nibble wrong");

  pad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_pwr |=> pad_powerdown_n == $past(pwdata[`PWR_PADS_N])
      && timing_clk_a_oe == !$past(pwdata[`PWR_OE_A_N]))
    else $error("pad power-down or clock A exception wrong");

  linemem_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_pwr |=> decoder_linemem_pd == $past(pwdata[`PWR_LINEMEM]))
    else $error("line memory power-down wrong");

  comb_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_pwr |=> comb_decoder_pd_n == $past(pwdata[`PWR_COMB_N]))
    else $error("comb decoder power-down wrong");

  clk_c_oe_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_pwr |=> timing_clk_c_oe
      == (!$past(pwdata[`PWR_OE_C_N]) && $past(pwdata[`PWR_PADS_N])))
    else $error("timing clock C enable wrong");

  dc_pd_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_at_pwr |=> dc_iface_pd_n == $past(pwdata[`PWR_DC_N]))
    else $error("dc interface power-down wrong");

endmodule : panel_clock_window_power_regs

// ---- panel_driver_model.sv ----
// behavioural panel driver: counts pixel clock edges while pads are on
`timescale 1ns/1ps

module panel_driver_model (
  // clock and pads
  input wire logic pix_clk,
  input wire logic pads_on,
  input wire logic clear,
  // observed edge count
  output int edges
);
  // a powered-down pad delivers no clock to the drivers
  always @(posedge pix_clk or posedge clear)
  begin
    if (clear)
      edges <= 0;
    else if (pads_on)
      edges <= edges + 1;
  end
endmodule : panel_driver_model

// ---- test_panel_clock_window_power_regs.sv ----
// testbench for the panel clock, window and power register bank
`timescale 1ns/1ps

module test_panel_clock_window_power_regs;
  logic pclk, presetn, psel, penable, pwrite, serial_rgb_en, pll_clk, ref_clk, clear;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err;
  logic [6:0] pll_fb_div;
  logic [4:0] pll_ref_div;
  logic [1:0] clk_src_select, pll_extra_div, pll_post_div;
  logic display_pll_powerdown, pll_output_double_div, pix_clk, subpixel_aa_en;
  logic pad_powerdown_n, other_pads_en, decoder_linemem_pd, comb_decoder_pd_n;
  logic timing_clk_a_oe, timing_clk_b_oe, timing_clk_c_oe, dc_iface_pd_n;
  logic [3:0] phase_clk_a, phase_clk_c, phase_aux_div;
  logic [11:0] main_win_h_start, main_win_v_start, main_win_h_size, main_win_v_size;
  int edges;
  int n_fail = 0;
  int num_checks = 0;
  logic [7:0] idx_tab [15] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD8, 8'hD9,
    8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE0};
  logic [7:0] rst_tab [15] = '{8'h15, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'hE0, 8'h01, 8'hEA, 8'h00, 8'h9C};
  logic [7:0] pw_tab [5] = '{8'h00, 8'hFF, 8'h55, 8'hAA, 8'h9C};
  wire [47:0] win = {main_win_v_size, main_win_h_size, main_win_v_start, main_win_h_start};

  panel_clock_window_power_regs i_panel_clock_window_power_regs (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .serial_rgb_en, .pll_clk, .ref_clk, .pll_fb_div, .pll_ref_div, .clk_src_select,
    .display_pll_powerdown, .pll_output_double_div, .pll_extra_div, .pll_post_div, .pix_clk,
    .phase_clk_a, .phase_clk_c, .phase_aux_div, .subpixel_aa_en, .main_win_h_start,
    .main_win_v_start, .main_win_h_size, .main_win_v_size, .pad_powerdown_n, .other_pads_en,
    .decoder_linemem_pd, .comb_decoder_pd_n, .timing_clk_a_oe, .timing_clk_b_oe,
    .timing_clk_c_oe, .dc_iface_pd_n
  );

  panel_driver_model i_panel_driver_model (
    .pix_clk, .pads_on(pad_powerdown_n), .clear, .edges
  );

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // one apb transfer; the request holds until pready is seen high
  task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task t_reset;
    for (int i = 0; i < 15; i++)
    begin
      xfer(1'b0, idx_tab[i], 8'h00);
      check(rd, {24'h0, rst_tab[i]});
      check({31'h0, err}, 32'h0);
    end
    check({20'h0, main_win_h_size}, 32'h1E0);
    check({28'h0, timing_clk_c_oe, timing_clk_b_oe, timing_clk_a_oe, pad_powerdown_n}, 32'h3);
  endtask : t_reset

  task t_fields;
    for (int i = 0; i < 15; i++)
    begin
      xfer(1'b1, idx_tab[i], 8'hFF);
      xfer(1'b0, idx_tab[i], 8'h00);
      check(rd, 32'hFF);
    end
    xfer(1'b1, 8'hC8, 8'hAA);
    xfer(1'b1, 8'hC9, 8'hE9);
    xfer(1'b1, 8'hCA, 8'h9E);
    xfer(1'b1, 8'hCB, 8'h5A);
    xfer(1'b1, 8'hCC, 8'hC3);
    xfer(1'b1, 8'hCD, 8'hFE);
    @(negedge pclk);
    check({1'b0, pll_fb_div, pll_ref_div, clk_src_select, display_pll_powerdown,
      pll_output_double_div, pll_post_div, phase_clk_a, phase_aux_div, phase_clk_c,
      subpixel_aa_en}, {1'b0, 7'h2A, 5'h09, 2'b10, 1'b0, 1'b1, 2'b10, 4'h5, 4'hA, 4'hC,
      1'b0});
  endtask : t_fields

  task t_window;
    logic [7:0] lo, hi;
    for (int k = 0; k < 4; k++)
    begin
      lo = 8'h5A + 8'(k * 33);
      hi = {4'hA, 4'(k * 5)};
      xfer(1'b1, 8'hD8 + 8'(2 * k), lo);
      xfer(1'b1, 8'hD9 + 8'(2 * k), hi);
      @(negedge pclk);
      check({20'h0, win[k * 12 +: 12]}, {20'h0, hi[3:0], lo});
      xfer(1'b0, 8'hD9 + 8'(2 * k), 8'h00);
      check(rd, {24'h0, hi});
    end
  endtask : t_window

  task t_mux;
    logic ok;
    for (int s = 0; s < 4; s++)
    begin
      xfer(1'b1, 8'hCA, {2'(s), 6'h01});
      clear <= 1'b1;
      @(posedge pclk);
      clear <= 1'b0;
      repeat (10) @(posedge pclk);
      ok = s == 0 ? edges > 20 : s == 1 ? (edges > 5 && edges < 20) : edges == 0;
      check({31'h0, ok}, 32'h1);
    end
  endtask : t_mux

  task t_extra;
    logic [1:0] e;
    for (int s = 0; s < 2; s++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        @(posedge pclk);
        serial_rgb_en <= s[0];
        xfer(1'b1, 8'hCA, {4'h0, 2'(c), 2'b01});
        repeat (2) @(negedge pclk);
        e = (s == 1 && c < 2) ? 2'(c) : 2'b00;
        check({30'h0, pll_extra_div}, {30'h0, e});
      end
    end
  endtask : t_extra

  task t_power;
    logic [7:0] v;
    for (int i = 0; i < 5; i++)
    begin
      v = pw_tab[i];
      xfer(1'b1, 8'hE0, v);
      @(negedge pclk);
      check({24'h0, pad_powerdown_n, other_pads_en, decoder_linemem_pd, comb_decoder_pd_n,
        timing_clk_c_oe, timing_clk_b_oe, timing_clk_a_oe, dc_iface_pd_n}, {24'h0, v[7], v[7],
        v[6], v[4], ~v[3] & v[7], ~v[2], ~v[1], v[0]});
    end
  endtask : t_power

  // unmapped places answer with an error and must not disturb neighbours
  task t_unmapped;
    xfer(1'b0, 8'hC7, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    xfer(1'b1, 8'hCE, 8'h01);
    xfer(1'b0, 8'hCD, 8'h00);
    check(rd, 32'hFE);
  endtask : t_unmapped

  // ---------------------------------------------
  // clocks, sequence and watchdog
  // ---------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    pll_clk = 1'b0;
    forever #5 pll_clk = ~pll_clk;
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #15 ref_clk = ~ref_clk;
  end

  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, serial_rgb_en, clear} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_fields();
    t_window();
    t_mux();
    t_extra();
    t_power();
    t_unmapped();
    print_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    print_verdict();
  end
endmodule : test_panel_clock_window_power_regs
